// ---- core/mcd_card.sv ----
// Function
// - Each answered memory cycle takes three clocks with one wait state.
// - Byte moves with one parity bit, word with two; generate and check.
// - Two byte lanes form a word; either lane is accessible alone.
// - A read parity mismatch asserts the channel-check line.
// - Channel check holds until the host writes this card.
// - Memory may sit in the base window, zero up to 640KB.
// - Memory may sit in the expansion window, 1024KB to 16,256KB.
// - Never answer 640KB to 1024KB or 16,256KB to 16,384KB.
// - Split mode fills base to 640KB; the rest goes to expansion.
// - Contiguous mode maps all capacity below 16,256KB gap-free from the expansion start.
// - Never decode the read-only memory region from FF0000 upward.
// - Five switches pick expansion start, 1MB to 15.5MB.
// - Two switches pick base start, including 256KB or 512KB.
// - Decoded range grows with installed memory; start stays fixed.
// - One switch enables the card's I/O ports when on.
// - Banks of two nine-bit modules add 512KB, 1024KB or 2048KB.
// - Mixed sizes: first two banks smallest, later banks next size.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"

module mcd_card #(
    parameter int AW = 10,
    parameter int WAIT_STATES = `MCD_WAIT_STATES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host memory channel
    input wire logic [23:0] addr_i,
    input wire logic byte_high_n_i,
    input wire logic memory_read_command_i,
    input wire logic memory_write_command_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic ready_o,
    output logic io_check_n_o,
    // Board switches and population
    input wire logic [4:0] sw_exp_start_i,
    input wire logic [1:0] sw_base_start_i,
    input wire logic sw_io_enable_i,
    input wire logic [2:0] banks_i,
    input wire mcd_pkg::mcd_density_type density_i,
    output logic io_ports_enable_o,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq_o
);
    import mcd_pkg::*;

    mcd_state_type state, next_state;
    logic hit;
    logic [14:0] offset_kb;
    logic [4:0] units;
    logic [AW-1:0] index;
    logic [1:0] lanes, lane_we;
    logic is_read;
    logic [7:0] wait_cnt;
    logic [17:0] rdata, wdata;
    logic par_err;
    logic check_active;
    logic par_inv;
    logic [`MCD_EV_WIDTH-1:0] ev_status, ev_enable, ev_set, ev_clr;
    logic wb_req, wb_wr;

    // Even parity over one byte, optionally inverted to inject errors
    function automatic logic lane_parity(input logic [7:0] b,
                                         input logic inv);
        lane_parity = (^b) ^ inv;
    endfunction

    // Byte lanes selected by address bit 0 and the high-byte enable
    function automatic logic [1:0] lane_select(input logic a0,
                                               input logic bhe_n);
        lane_select = {!bhe_n, !a0};
    endfunction

    mcd_decode u_decode (
        .kb_i(addr_i[23:10]),
        .sw_exp_start_i(sw_exp_start_i),
        .sw_base_start_i(sw_base_start_i),
        .banks_i(banks_i),
        .density_i(density_i),
        .hit_o(hit),
        .offset_kb_o(offset_kb),
        .units_o(units)
    );

    mcd_store #(
        .AW(AW)
    ) u_store (
        .clk_i(clk_i),
        .index_i(index),
        .lane_we_i(lane_we),
        .wdata_i(wdata),
        .rdata_o(rdata)
    );

    assign io_ports_enable_o = sw_io_enable_i;

    // Cycle sequencer: command edge, wait state, transfer, hold
    always_comb
    begin
        next_state = state;
        case (state)
            MCD_ST_IDLE:
            begin
                if ((memory_read_command_i ^ memory_write_command_i)
                    && hit && lane_select(addr_i[0], byte_high_n_i) != 2'h0)
                begin
                    next_state = MCD_ST_WAIT;
                end
            end
            MCD_ST_WAIT:
            begin
                if (wait_cnt == 8'(WAIT_STATES - 1))
                begin
                    next_state = MCD_ST_XFER;
                end
            end
            MCD_ST_XFER:
            begin
                next_state = MCD_ST_HOLD;
            end
            MCD_ST_HOLD:
            begin
                if (!memory_read_command_i && !memory_write_command_i)
                begin
                    next_state = MCD_ST_IDLE;
                end
            end
            default:
            begin
                next_state = MCD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= MCD_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state != MCD_ST_WAIT)
        begin
            wait_cnt <= 8'h0;
        end
        else
        begin
            wait_cnt <= wait_cnt + 8'h1;
        end
    end

    // Latch the decoded cycle when it starts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            index <= '0;
            lanes <= 2'h0;
            is_read <= 1'b0;
        end
        else if (state == MCD_ST_IDLE)
        begin
            index <= AW'({offset_kb, addr_i[9:1]});
            lanes <= lane_select(addr_i[0], byte_high_n_i);
            is_read <= memory_read_command_i;
        end
    end

    // Store on the edge that ends the wait state
    assign lane_we = (state == MCD_ST_WAIT && next_state == MCD_ST_XFER
                      && !is_read) ? lanes : 2'h0;
    assign wdata = {lane_parity(data_i[15:8], par_inv), data_i[15:8],
                    lane_parity(data_i[7:0], par_inv), data_i[7:0]};

    // Check only the lanes taking part in the read
    assign par_err = is_read && state == MCD_ST_WAIT
                     && next_state == MCD_ST_XFER
                     && ((lanes[0] && rdata[8] != lane_parity(rdata[7:0],
                                                              1'b0))
                         || (lanes[1] && rdata[17] != lane_parity(rdata[16:9],
                                                                  1'b0)));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_o <= 16'h0000;
        end
        else if (state == MCD_ST_WAIT && next_state == MCD_ST_XFER
                 && is_read)
        begin
            data_o <= {lanes[1] ? rdata[16:9] : 8'h00,
                       lanes[0] ? rdata[7:0] : 8'h00};
        end
    end

    // Drive data only during the data phase of a decoded read
    assign data_oe_o = is_read && memory_read_command_i
                       && (state == MCD_ST_XFER || state == MCD_ST_HOLD);
    // Channel not ready during the inserted wait state
    assign ready_o = (state != MCD_ST_WAIT);

    // Channel check: a parity error sets it, a write to the card clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            check_active <= 1'b0;
        end
        else if (par_err)
        begin
            check_active <= 1'b1;
        end
        else if (state == MCD_ST_WAIT && !is_read)
        begin
            check_active <= 1'b0;
        end
    end

    assign io_check_n_o = !check_active;

    // Wishbone slave: one wait cycle, ack dropped after one cycle
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land on the edge at which the master samples ack
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            par_inv <= `MCD_CTRL_RESET;
        end
        else if (wb_wr && wb_adr_i == `MCD_REG_CTRL)
        begin
            par_inv <= wb_dat_i[`MCD_CTRL_PAR_INV];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ev_enable <= `MCD_EV_RESET;
        end
        else if (wb_wr && wb_adr_i == `MCD_REG_ENABLE)
        begin
            ev_enable <= wb_dat_i[`MCD_EV_WIDTH-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always_comb
    begin
        ev_set = '0;
        ev_set[`MCD_EV_PARITY] = par_err;
        ev_set[`MCD_EV_WRITE] = |lane_we;
        ev_set[`MCD_EV_READ] = is_read && state == MCD_ST_XFER;
        ev_clr = (wb_wr && wb_adr_i == `MCD_REG_CLEAR)
                 ? wb_dat_i[`MCD_EV_WIDTH-1:0] : '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ev_status <= `MCD_EV_RESET;
        end
        else
        begin
            ev_status <= (ev_status & ~ev_clr) | ev_set;
        end
    end

    assign irq_o = |(ev_status & ev_enable);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (wb_req && !wb_we_i)
        begin
            case (wb_adr_i)
                `MCD_REG_CTRL: wb_dat_o <= {31'h0, par_inv};
                `MCD_REG_STATUS: wb_dat_o <= 32'(ev_status);
                `MCD_REG_ENABLE: wb_dat_o <= 32'(ev_enable);
                `MCD_REG_INFO: wb_dat_o <= {19'h0, units, 6'h0,
                                            sw_io_enable_i, check_active};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- core/mcd_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"

module mcd_decode (
    // Host address in kilobytes
    input wire logic [13:0] kb_i,
    // Board switches and population
    input wire logic [4:0] sw_exp_start_i,
    input wire logic [1:0] sw_base_start_i,
    input wire logic [2:0] banks_i,
    input wire mcd_pkg::mcd_density_type density_i,
    // Result
    output logic hit_o,
    output logic [14:0] offset_kb_o,
    output logic [4:0] units_o
);
    import mcd_pkg::*;

    logic [14:0] kb, cap, bs, base_len, es, exp_len, room;
    logic [4:0] sw_clip;
    logic split, base_hit, exp_hit, reserved;

    function automatic logic [4:0] bank_units(input logic [2:0] n,
                                              input mcd_density_type d);
        logic [4:0] u;
        u = {2'h0, n};
        case (d)
            MCD_DEN_256K: bank_units = u;
            MCD_DEN_512K: bank_units = u << 1;
            MCD_DEN_1M: bank_units = u << 2;
            MCD_DEN_MIXED: bank_units = (n <= 3'h2) ? u : ((u << 1) - 5'h2);
            default: bank_units = 5'h0;
        endcase
    endfunction

    always_comb
    begin
        kb = {1'b0, kb_i};
        units_o = bank_units(banks_i, density_i);
        cap = 15'(units_o * `MCD_UNIT_KB);
        split = (sw_base_start_i != 2'h0);
        case (sw_base_start_i)
            2'h1: bs = `MCD_BASE_256_KB;
            2'h2: bs = `MCD_BASE_512_KB;
            default: bs = 15'h0;
        endcase
        room = `MCD_BASE_TOP_KB - bs;
        base_len = !split ? 15'h0 : (cap < room) ? cap : room;
        sw_clip = (sw_exp_start_i > `MCD_EXP_SW_MAX) ? `MCD_EXP_SW_MAX
                                                     : sw_exp_start_i;
        es = 15'(`MCD_EXP_BOTTOM_KB + sw_clip * `MCD_EXP_STEP_KB);
        exp_len = cap - base_len;
        reserved = (kb >= `MCD_BASE_TOP_KB && kb < `MCD_EXP_BOTTOM_KB)
                   || kb >= `MCD_EXP_TOP_KB || kb >= `MCD_ROM_START_KB;
        base_hit = split && kb >= bs && kb < bs + base_len;
        exp_hit = kb >= es && kb < es + exp_len;
        hit_o = (base_hit || exp_hit) && !reserved;
        offset_kb_o = base_hit ? kb - bs : kb - es + base_len;
    end
endmodule

`default_nettype wire

// ---- core/mcd_params.svh ----
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define MCD_REG_CTRL 8'h00
`define MCD_REG_STATUS 8'h04
`define MCD_REG_CLEAR 8'h08
`define MCD_REG_ENABLE 8'h0C
`define MCD_REG_INFO 8'h10

// Control register fields
`define MCD_CTRL_PAR_INV 0
`define MCD_CTRL_RESET 1'h0

// Event bit positions in status, clear and enable
`define MCD_EV_PARITY 0
`define MCD_EV_WRITE 1
`define MCD_EV_READ 2
`define MCD_EV_WIDTH 3
`define MCD_EV_RESET 3'h0

// Info register fields
`define MCD_INFO_CHECK 0
`define MCD_INFO_IOEN 1
`define MCD_INFO_UNITS_LSB 8

// Address map in kilobytes
`define MCD_BASE_TOP_KB 15'h0280
`define MCD_EXP_BOTTOM_KB 15'h0400
`define MCD_EXP_TOP_KB 15'h3F80
`define MCD_ROM_START_KB 15'h3FC0
`define MCD_EXP_STEP_KB 15'h0200
`define MCD_EXP_SW_MAX 5'h1D
`define MCD_BASE_256_KB 15'h0100
`define MCD_BASE_512_KB 15'h0200
`define MCD_UNIT_KB 15'h0200

// Bus cycle timing
`define MCD_WAIT_STATES 1
`define MCD_CYCLE_CLOCKS 3

`endif

// ---- core/mcd_pkg.sv ----
package mcd_pkg;

    typedef enum logic [3:0] {
        MCD_ST_IDLE = 4'b0001,
        MCD_ST_WAIT = 4'b0010,
        MCD_ST_XFER = 4'b0100,
        MCD_ST_HOLD = 4'b1000
    } mcd_state_type;

    typedef enum logic [1:0] {
        MCD_DEN_256K = 2'h0,
        MCD_DEN_512K = 2'h1,
        MCD_DEN_1M = 2'h2,
        MCD_DEN_MIXED = 2'h3
    } mcd_density_type;

endpackage

// ---- core/mcd_store.sv ----
`timescale 1ns/10ps
`default_nettype none

module mcd_store #(
    parameter int AW = 10
) (
    // Clock
    input wire logic clk_i,
    // Access
    input wire logic [AW-1:0] index_i,
    input wire logic [1:0] lane_we_i,
    input wire logic [17:0] wdata_i,
    output logic [17:0] rdata_o
);
    logic [17:0] mem [0:(2**AW)-1];

    // Each lane holds eight data bits and its parity bit
    always_ff @(posedge clk_i)
    begin
        if (lane_we_i[0])
        begin
            mem[index_i][8:0] <= wdata_i[8:0];
        end
        if (lane_we_i[1])
        begin
            mem[index_i][17:9] <= wdata_i[17:9];
        end
    end

    assign rdata_o = mem[index_i];
endmodule

`default_nettype wire

// ---- testbench/mcd_card_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module mcd_card_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host channel
    input wire logic [23:0] addr_i,
    input wire logic memory_read_command_i,
    input wire logic memory_write_command_i,
    input wire logic data_oe_o,
    input wire logic ready_o,
    input wire logic io_check_n_o,
    // Switches and register bus
    input wire logic sw_io_enable_i,
    input wire logic io_ports_enable_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic cmd;
    logic resv;
    logic [13:0] kb;
    assign cmd = memory_read_command_i | memory_write_command_i;
    assign kb = addr_i[23:10];
    // Holes below 1MB and above the expansion top
    assign resv = (kb >= 14'h0280 && kb < 14'h0400) || kb >= 14'h3F80;

    a_wait_one: assert property ($fell(ready_o) |=> ready_o)
        else $error("wait state not exactly one clock");
    a_wait_cause: assert property ($fell(ready_o) |-> $past(cmd))
        else $error("wait state without a command");
    a_resv_quiet: assert property (cmd && resv |=> ready_o)
        else $error("reserved address answered");
    a_oe_read: assert property (
        data_oe_o |-> memory_read_command_i && ready_o)
        else $error("data driven outside a read");
    a_oe_after: assert property ($rose(data_oe_o) |-> $past(!ready_o))
        else $error("data driven before the wait state");
    a_check_hold: assert property (
        !io_check_n_o && !memory_write_command_i |=> !io_check_n_o)
        else $error("channel check dropped without a write");
    a_check_cause: assert property (
        $fell(io_check_n_o) |-> $past(memory_read_command_i))
        else $error("channel check not caused by a read");
    a_io_gate: assert property (io_ports_enable_o == sw_io_enable_i)
        else $error("port enable does not follow the switch");
    a_wb_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    cover property ($fell(io_check_n_o));
    cover property ($rose(data_oe_o));
    cover property ($fell(ready_o) && memory_write_command_i);
endmodule

`default_nettype wire

// ---- testbench/mcd_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module mcd_host (
    // Clock
    input wire logic clk_i,
    // Channel from the card
    input wire logic ready_i,
    input wire logic [15:0] rdata_i,
    // Channel to the card
    output logic [23:0] addr_o,
    output logic byte_high_n_o,
    output logic rd_o,
    output logic wr_o,
    output logic [15:0] wdata_o
);
    initial
    begin
        addr_o = 24'h000000;
        byte_high_n_o = 1'b1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 16'hA5C3;
    end

    // One memory cycle; hit is low when the card never answered
    task automatic cycle(input logic [23:0] a, input logic bn,
        input logic w, input logic [15:0] d,
        output logic [15:0] q, output logic hit);
        int n;
        logic seen;
        n = 0;
        seen = 0;
        hit = 0;
        q = 16'h0000;
        addr_o <= a;
        byte_high_n_o <= bn;
        rd_o <= !w;
        wr_o <= w;
        if (w)
            wdata_o <= d;
        // Hold until the wait state has passed and ready is back
        while (!hit && n < 5)
        begin
            @(posedge clk_i);
            n++;
            if (ready_i === 1'b0)
                seen = 1;
            else if (seen)
            begin
                hit = 1;
                q = rdata_i;
            end
        end
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        // Released bus shows the inverse, not stale data
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// ---- testbench/test_memory_card_decode_parity.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"

module test_memory_card_decode_parity;
    import mcd_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic [23:0] addr_i;
    logic byte_high_n_i, memory_read_command_i, memory_write_command_i;
    logic [15:0] data_i, data_o;
    logic data_oe_o, ready_o, io_check_n_o, io_ports_enable_o, irq_o;
    logic [4:0] sw_exp_start_i = 5'h00;
    logic [1:0] sw_base_start_i = 2'h2;
    logic sw_io_enable_i = 1;
    logic [2:0] banks_i = 3'h1;
    mcd_density_type density_i = MCD_DEN_256K;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [15:0] rq;
    logic rh;
    int n_mismatch = 0, tests_run = 0, cycles = 0;

    always #12.5 clk_i = ~clk_i;

    mcd_card uut (.clk_i, .rst_i, .addr_i, .byte_high_n_i,
        .memory_read_command_i, .memory_write_command_i, .data_i, .data_o,
        .data_oe_o, .ready_o, .io_check_n_o, .sw_exp_start_i,
        .sw_base_start_i, .sw_io_enable_i, .banks_i, .density_i,
        .io_ports_enable_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);
    mcd_host host (.clk_i, .ready_i(ready_o), .rdata_i(data_o),
        .addr_o(addr_i), .byte_high_n_o(byte_high_n_i),
        .rd_o(memory_read_command_i), .wr_o(memory_write_command_i),
        .wdata_o(data_i));

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask

    // Write then read back one place; misses must stay silent
    task automatic probe(input logic [23:0] a, input logic bn,
        input logic e, input logic [15:0] d);
        logic [15:0] r;
        logic h;
        host.cycle(a, bn, 1'b1, d, r, h);
        chk("write answered", 32'(e), 32'(h));
        host.cycle(a, bn, 1'b0, 16'h0000, r, h);
        chk("read answered", 32'(e), 32'(h));
        if (e)
            chk("read data", {16'h0, !bn ? d[15:8] : 8'h00,
                !a[0] ? d[7:0] : 8'h00}, 32'(r));
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(`MCD_REG_STATUS, 0, 0);
        chk("status", 32'h0, q);
        wb(`MCD_REG_INFO, 0, 0);
        chk("info", 32'h00000102, q);
        wb(8'h20, 0, 0);
        chk("unmapped", 32'h0, q);
        probe(24'h080000, 0, 1, 16'h1234);
        probe(24'h09FFFC, 0, 1, 16'hBEEF);
        probe(24'h100002, 0, 1, 16'h5AC3);
        probe(24'h100005, 0, 1, 16'h7E00);
        probe(24'h100006, 1, 1, 16'h0081);
        probe(24'h15FFFE, 0, 1, 16'hC0DE);
        probe(24'h160000, 0, 0, 16'h1111);
        probe(24'h0A0000, 0, 0, 16'h2222);
        probe(24'h07FFFE, 0, 0, 16'h3333);
        probe(24'hFF0000, 0, 0, 16'h4444);
        probe(24'hFE0000, 0, 0, 16'h5555);
        banks_i <= 3'h2;
        probe(24'h160000, 0, 1, 16'h6666);
        sw_base_start_i <= 2'h0;
        sw_exp_start_i <= 5'h01;
        banks_i <= 3'h1;
        probe(24'h180000, 0, 1, 16'h7777);
        probe(24'h080000, 0, 0, 16'h8888);
        probe(24'h200000, 0, 0, 16'h9999);
        sw_exp_start_i <= 5'h1F;
        probe(24'hF80000, 0, 1, 16'hAAAA);
        probe(24'hFE0000, 0, 0, 16'hBBBB);
        sw_exp_start_i <= 5'h01;
        banks_i <= 3'h3;
        sw_io_enable_i <= 0;
        for (int d = 0; d < 4; d++)
        begin
            density_i <= mcd_density_type'(d);
            wb(`MCD_REG_INFO, 0, 0);
            chk("units", {d == 3 ? 5'h04 : 5'(3 << d), 8'h00}, q);
        end
        chk("port enable", 32'h0, 32'(io_ports_enable_o));
        // Bad parity through the invert control, then read back
        probe(24'h180000, 0, 1, 16'h0F0F);
        wb(`MCD_REG_CTRL, 1, 1);
        probe(24'h180000, 0, 1, 16'h0F0F);
        chk("check", 32'h0, 32'(io_check_n_o));
        wb(`MCD_REG_CTRL, 1, 0);
        wb(`MCD_REG_ENABLE, 1, 1);
        chk("irq on", 32'h1, 32'(irq_o));
        wb(`MCD_REG_ENABLE, 1, 0);
        chk("irq masked", 32'h0, 32'(irq_o));
        wb(`MCD_REG_ENABLE, 1, 1);
        wb(`MCD_REG_CLEAR, 1, 7);
        chk("irq cleared", 32'h0, 32'(irq_o));
        chk("check held", 32'h0, 32'(io_check_n_o));
        host.cycle(24'h180000, 0, 1, 16'h1357, rq, rh);
        chk("clear write answered", 32'h1, 32'(rh));
        chk("check cleared", 32'h1, 32'(io_check_n_o));
        wb(`MCD_REG_STATUS, 0, 0);
        chk("status", 32'h2, q);
        conclude();
    end
endmodule

bind mcd_card mcd_card_chk u_chk (.clk_i, .rst_i, .addr_i,
    .memory_read_command_i, .memory_write_command_i, .data_oe_o, .ready_o,
    .io_check_n_o, .sw_io_enable_i, .io_ports_enable_o, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o);

`default_nettype wire
